// ---- rtl/ebmrs_block_memory.v ----
// Embedded block memory with asynchronous and global set/reset handling.
`timescale 1ns/1ps
// ========================================
// Contract
// RULE1 - Fabric holds every clock enable low at least one cycle before asserting any reset.
// RULE2 - Fabric keeps clock enables low until one cycle after reset rises, then re-enables; the fabric model re-enables one cycle after gsr_out falls.
// RULE3 - With enables left high, reset changes only after both clocks were steady one fastest period.
// RULE4 - Reset release meets the synchronous reset setup before the next active clock edge.
// RULE5 - With preloaded contents, global set/reset is disabled or released before outputs go active.
// RULE6 - The same sequencing holds for RAM, ROM, FIFO and shift register modes.
// RULE7 - In FIFO mode global set/reset is always enabled and the write and read strobes act as enables.
// RULE8 - In FIFO mode the read-pointer reset is sequenced to the read strobe, full reset to both strobes.
// RULE9 - Full FIFO reset and read-pointer reset act asynchronously on assertion.
// RULE10 - In shift register mode global set/reset is always enabled and the local reset is asynchronous.
// RULE11 - A synchronous reset with global set/reset disabled needs no sequencing.
// RULE12 - While an asynchronous reset is asserted, outputs and pointers stay in their reset state.
`include "ebmrs_regs.vh"

module ebmrs_block_memory #(
   parameter DATA_W = 8,
   parameter ADDR_W = 4
) (
   input  wire              clk_in,
   input  wire              reset_n_in,
   input  wire [1:0]        mode_in,
   input  wire              global_set_reset_en_in,
   input  wire              global_set_reset_in,
   input  wire              sync_reset_en_in,
   input  wire              local_reset_in,
   input  wire              read_pointer_reset_in,
   input  wire              write_enable_in,
   input  wire              read_enable_in,
   input  wire [ADDR_W-1:0] write_addr_in,
   input  wire [ADDR_W-1:0] read_addr_in,
   input  wire [DATA_W-1:0] write_data_in,
   output reg  [DATA_W-1:0] read_data_out,
   output reg               fifo_empty_out,
   output reg               fifo_full_out
);

   localparam DEPTH = 1 << ADDR_W;

   // ========================================
   // Reset derivation
   wire fifo_mode;
   wire shift_mode;
   wire gsr_active;
   wire async_local;
   wire full_rst_n;
   wire rp_rst_n;
   wire sync_rst;

   assign fifo_mode  = (mode_in == `EBMRS_MODE_FIFO);
   assign shift_mode = (mode_in == `EBMRS_MODE_SHIFT);
   // FIFO and shift modes ignore the disable and always honour global set/reset.
   assign gsr_active = global_set_reset_in & (global_set_reset_en_in | fifo_mode | shift_mode); // RULE7 RULE10
   // Local reset is asynchronous unless the synchronous form is chosen outside FIFO and shift modes.
   assign async_local = local_reset_in & (fifo_mode | shift_mode | ~sync_reset_en_in); // RULE10 RULE6
   assign sync_rst    = local_reset_in & sync_reset_en_in & ~fifo_mode & ~shift_mode; // RULE11
   assign full_rst_n  = reset_n_in & ~gsr_active & ~async_local; // RULE9 RULE12
   assign rp_rst_n    = full_rst_n & ~(fifo_mode & read_pointer_reset_in); // RULE9 RULE8

   // ========================================
   // Storage
   // Contents are not cleared by any reset, so preloaded data survives.
   reg  [DATA_W-1:0] mem_r [0:DEPTH-1];
   reg  [ADDR_W:0]   wptr_r;
   reg  [ADDR_W:0]   rptr_r;
   wire [ADDR_W:0]   level;
   wire              do_write;
   wire              do_read;
   integer           i;

   assign level    = wptr_r - rptr_r;
   assign do_write = write_enable_in & ~(fifo_mode & (level == DEPTH[ADDR_W:0])) & (mode_in != `EBMRS_MODE_ROM);
   assign do_read  = read_enable_in & ~(fifo_mode & (level == {(ADDR_W+1){1'b0}}));

   always @(posedge clk_in) begin
      if (shift_mode & write_enable_in) begin
         mem_r[0] <= write_data_in;
         for (i = 1; i < DEPTH; i = i + 1) begin
            mem_r[i] <= mem_r[i-1];
         end
      end else if (do_write & fifo_mode) begin
         mem_r[wptr_r[ADDR_W-1:0]] <= write_data_in;
      end else if (do_write) begin
         mem_r[write_addr_in] <= write_data_in;
      end
   end

   // ========================================
   // Pointers
   always @(posedge clk_in or negedge full_rst_n) begin
      if (!full_rst_n) begin
         wptr_r <= {(ADDR_W+1){`EBMRS_PTR_RST}}; // RULE12
      end else if (fifo_mode & do_write) begin
         wptr_r <= wptr_r + {{ADDR_W{1'b0}}, 1'b1};
      end
   end

   always @(posedge clk_in or negedge rp_rst_n) begin
      if (!rp_rst_n) begin
         rptr_r <= {(ADDR_W+1){`EBMRS_PTR_RST}}; // RULE12
      end else if (fifo_mode & do_read) begin
         rptr_r <= rptr_r + {{ADDR_W{1'b0}}, 1'b1};
      end
   end

   // ========================================
   // Output register and flags
   always @(posedge clk_in or negedge rp_rst_n) begin
      if (!rp_rst_n) begin
         read_data_out <= {DATA_W{`EBMRS_DATA_RST}}; // RULE12
      end else if (sync_rst) begin
         read_data_out <= {DATA_W{`EBMRS_DATA_RST}}; // RULE11
      end else if (shift_mode & write_enable_in) begin
         read_data_out <= mem_r[DEPTH-1];
      end else if (fifo_mode & do_read) begin
         read_data_out <= mem_r[rptr_r[ADDR_W-1:0]];
      end else if (~fifo_mode & ~shift_mode & read_enable_in) begin
         read_data_out <= mem_r[read_addr_in];
      end
   end

   // Flags lag pointers by one cycle, a trade for registered outputs.
   always @(posedge clk_in or negedge rp_rst_n) begin
      if (!rp_rst_n) begin
         fifo_empty_out <= 1'b1;
         fifo_full_out  <= 1'b0;
      end else begin
         fifo_empty_out <= fifo_mode & (level == {(ADDR_W+1){1'b0}});
         fifo_full_out  <= fifo_mode & (level == DEPTH[ADDR_W:0]);
      end
   end

endmodule // ebmrs_block_memory

// ---- rtl/ebmrs_regs.vh ----
// Constants for the embedded block memory reset sequencing block.
`ifndef EBMRS_REGS_VH
`define EBMRS_REGS_VH
// ========================================
// Memory configuration modes
`define EBMRS_MODE_RAM   2'h0
`define EBMRS_MODE_ROM   2'h1
`define EBMRS_MODE_FIFO  2'h2
`define EBMRS_MODE_SHIFT 2'h3
// ========================================
// Reset values
`define EBMRS_DATA_RST   1'h0
`define EBMRS_PTR_RST    1'h0
`endif

// ---- test/ebmrs_props.sv ----
// Checker for the block memory reset behaviour.
`timescale 1ns/1ps
module ebmrs_props #(parameter DATA_W=8) (input wire clk_in,reset_n_in,global_set_reset_in,global_set_reset_en_in,
   input wire [1:0] mode_in,input wire local_reset_in,read_pointer_reset_in,sync_reset_en_in,
   input wire [DATA_W-1:0] read_data_out,input wire fifo_empty_out,fifo_full_out);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   chk_gsr_clears: assert property (global_set_reset_in&&global_set_reset_en_in|->read_data_out==0&&!fifo_full_out)
      else $error("data not cleared by global reset");
   chk_fifo_gsr_forced: assert property (mode_in==2'h2&&global_set_reset_in|->fifo_empty_out&&!fifo_full_out)
      else $error("fifo flags not cleared by global reset");
   chk_rdptr_async: assert property (mode_in==2'h2&&read_pointer_reset_in|->fifo_empty_out&&read_data_out==0)
      else $error("read pointer reset ignored");
   chk_full_rst_async: assert property (mode_in==2'h2&&local_reset_in|->fifo_empty_out)
      else $error("fifo reset ignored");
   chk_shift_rst: assert property (mode_in==2'h3&&(local_reset_in||global_set_reset_in)|->read_data_out==0)
      else $error("shift reset ignored");
   chk_sync_rst: assert property (mode_in<2'h2&&sync_reset_en_in&&local_reset_in|=>read_data_out==0)
      else $error("sync reset ignored");
   chk_flags_excl: assert property (!(fifo_empty_out&&fifo_full_out))
      else $error("empty and full together");
   chk_rst_hold: assert property ($fell(global_set_reset_in)&&mode_in==2'h2|->fifo_empty_out)
      else $error("fifo left reset early");
   cover property (mode_in==2'h2&&read_pointer_reset_in);
   cover property (mode_in==2'h0&&global_set_reset_in);
   cover property (mode_in==2'h3&&local_reset_in);
endmodule // ebmrs_props
bind ebmrs_block_memory ebmrs_props #(.DATA_W(DATA_W)) i_ebmrs_props (.*);

// ---- test/ebmrs_fabric.sv ----
// Fabric model that sequences the global reset against the clock enables.
`timescale 1ns/1ps
module ebmrs_fabric (input wire clk_in,rst_n_in,rst_req_in,we_in,re_in,output reg gsr_out,output wire we_out,re_out);
   reg [1:0] st_r;
   // Gating the strobes here keeps the bench from ever breaking the enable window.
   assign we_out = we_in&&st_r==2'h0;
   assign re_out = re_in&&st_r==2'h0;
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin gsr_out <= 1'h0; st_r <= 2'h0; end
      else if (rst_req_in&&st_r==2'h0) st_r <= 2'h1;
      else if (st_r==2'h1) begin gsr_out <= 1'h1; st_r <= 2'h2; end
      else if (st_r==2'h2&&!rst_req_in) begin gsr_out <= 1'h0; st_r <= 2'h3; end
      else if (st_r==2'h3) st_r <= 2'h0;
   end
endmodule // ebmrs_fabric

// ---- test/test_ebmrs_block_memory.sv ----
// Testbench for the block memory reset sequencing.
`timescale 1ns/1ps
module test_ebmrs_block_memory;
   reg clk_in=0,reset_n_in=0,rq=0,we=0,re=0,gen=1,lr=0,rpr=0,sen=0;
   reg [1:0] md=2'h0; reg [3:0] ra=4'h0,wa=4'h0; reg [7:0] wd=8'h00; reg [11:0] rows[0:3];
   wire [7:0] q; wire emp,ful,global_set_reset,wen,ren;
   integer err_count=0,checks=0,cyc=0,i;
   always #50 clk_in = ~clk_in;
   ebmrs_fabric i_ebmrs_fabric (.clk_in(clk_in),.rst_n_in(reset_n_in),.rst_req_in(rq),.we_in(we),.re_in(re),.gsr_out(global_set_reset),
      .we_out(wen),.re_out(ren));
   ebmrs_block_memory i_ebmrs_block_memory (.clk_in(clk_in),.reset_n_in(reset_n_in),.mode_in(md),
      .global_set_reset_en_in(gen),.global_set_reset_in(global_set_reset),.sync_reset_en_in(sen),.local_reset_in(lr),
      .read_pointer_reset_in(rpr),.write_enable_in(wen),.read_enable_in(ren),.write_addr_in(wa),.read_addr_in(ra),
      .write_data_in(wd),.read_data_out(q),.fifo_empty_out(emp),.fifo_full_out(ful));
   task tick; begin @(posedge clk_in); #1; end endtask
   task cmp(input [7:0] g,e); begin checks=checks+1;
      if (g!==e) begin err_count=err_count+1; $display("[ERR] %0t %h %h",$time,g,e); end end endtask
   task wr(input [3:0] a,input [7:0] d); begin wa=a; wd=d; we=1; tick; we=0; end endtask
   task rd(input [3:0] a,input [7:0] e); begin ra=a; re=1; tick; re=0; cmp(q,e); end endtask
   task end_of_test; begin $display("errors %0d checks %0d",err_count,checks);
      if (err_count==0&&checks>0) $display("Test passed");
      else $display("Test failed");
      $finish; end endtask
   always @(posedge clk_in) begin cyc=cyc+1; if (cyc==2000) begin err_count=err_count+1; end_of_test; end end
   initial begin
      rows[0]=12'h0A5; rows[1]=12'hF3C; rows[2]=12'h7FF; rows[3]=12'h101;
      repeat (6) tick; reset_n_in=1; tick;
      for (i=0;i<4;i=i+1) begin wr(rows[i][11:8],rows[i][7:0]); rd(rows[i][11:8],rows[i][7:0]); end
      rq=1; repeat (3) tick; cmp(q,8'h00); rq=0; repeat (3) tick;
      rd(rows[1][11:8],rows[1][7:0]);
      sen=1; lr=1; tick; lr=0; sen=0; cmp(q,8'h00);
      md=2'h2; gen=0; tick; wr(4'h0,8'h11); tick; wr(4'h0,8'h22); tick; cmp(emp,1'h0);
      rq=1; repeat (3) tick; cmp(emp,1'h1); rq=0; repeat (3) tick;
      wr(4'h0,8'h5A); tick; rd(4'h0,8'h5A); tick; rpr=1; #1 cmp(q,8'h00); tick; rpr=0; tick;
      wr(4'h0,8'h33); tick; lr=1; #1 cmp(emp,1'h1); tick; lr=0; tick;
      we=1; repeat (16) tick; we=0; tick; cmp(ful,1'h1);
      md=2'h3; tick; wr(4'h0,8'h44); cmp(q,8'h33); tick;
      lr=1; #1 cmp(q,8'h00); tick; lr=0; tick;
      end_of_test;
   end
endmodule // test_ebmrs_block_memory
